// ==== hdl/dsr_ctl.sv ====
// Purpose: memory controller end, apb registers, makes the link clocks
// Assumes: link clock is clk divided by two times khalf
// Notes: one read burst per start command
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/10ps
module dsr_ctl
  import dsr_pkg::*;
#(
  parameter int KHALF = DSR_KHALF
) (
  input wire logic clk, // system clock
  input wire logic rst, // synchronous reset, high active
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  dsr_link_if.ctl lnk // link pins
);
  typedef struct packed {
    dsr_ctl_state_t st;
    logic [7:0] cnt;
    logic [3:0] po;
    logic [2:0] half;
    logic pll_n;
    logic single;
    logic done;
    logic [DSR_AW-1:0] addr;
    logic [DSR_DW-1:0] w0;
    logic [DSR_DW-1:0] w1;
    logic load_n;
    logic k;
  } dsr_ctl_st_t;
  dsr_ctl_st_t s_q, s_d;
  logic [DSR_DW-1:0] q_s;
  logic wr_en;
  logic [2:0] h_w1;

  // returning data is a pin input in this domain
  dsr_sync3 #(
    .W(DSR_DW),
    .INIT('0)
  ) u_q_sync (
    .clk(clk),
    .rst(rst),
    .din(lnk.q),
    .dout(q_s)
  );

  assign wr_en = psel & penable & pwrite;
  assign h_w1 = s_q.pll_n ? DSR_H_W1_SLOW : DSR_H_W1_FAST;

  always_comb
  begin
    s_d = s_q;
    // divider: k high for the first half of each period
    s_d.cnt = (s_q.cnt == 8'(2 * KHALF - 1)) ? 8'h00 : s_q.cnt + 8'h01;
    s_d.k = (s_d.cnt < 8'(KHALF));
    if (s_q.po != 4'h0 && s_q.cnt == 8'h00)
    begin
      s_d.po = s_q.po - 4'h1;
    end
    // register writes
    if (wr_en && paddr == DSR_CTRL)
    begin
      s_d.pll_n = pwdata[DSR_CTRL_PLLN];
      s_d.single = pwdata[DSR_CTRL_SINGLE];
      // strap only counts at power-on, so a new strap reruns the hold
      if (pwdata[DSR_CTRL_SINGLE] != s_q.single)
      begin
        s_d.po = 4'(DSR_PO_CYC);
      end
    end
    if (wr_en && paddr == DSR_ADDR)
    begin
      s_d.addr = pwdata[DSR_AW-1:0];
    end
    if (wr_en && paddr == DSR_STAT && pwdata[DSR_STAT_DONE])
    begin
      s_d.done = 1'h0;
    end
    // count half periods since the request edge
    if (s_q.cnt == 8'(KHALF - 1) || s_q.cnt == 8'(2 * KHALF - 1))
    begin
      s_d.half = s_q.half + 3'h1;
    end
    case (s_q.st)
      DSR_IDLE:
      begin
        if (wr_en && paddr == DSR_CTRL && pwdata[DSR_CTRL_START] && s_q.po == 4'h0)
        begin
          s_d.st = DSR_ISSUE;
        end
      end
      DSR_ISSUE:
      begin
        // present at k fall so it is steady at the next k rise
        if (s_q.cnt == 8'(KHALF))
        begin
          s_d.load_n = 1'h0;
          s_d.st = DSR_WAIT;
        end
      end
      DSR_WAIT:
      begin
        if (s_q.cnt == 8'h00 && !s_q.load_n)
        begin
          s_d.half = 3'h0;
        end
        if (s_q.cnt == 8'(KHALF))
        begin
          s_d.load_n = 1'h1;
        end
        // sample at the end of each data half, after the synchroniser lag
        if (s_q.load_n && s_q.half == h_w1 && s_d.half != s_q.half)
        begin
          s_d.w0 = q_s;
        end
        if (s_q.load_n && s_q.half == h_w1 + 3'h1 && s_d.half != s_q.half)
        begin
          s_d.w1 = q_s;
          s_d.done = 1'h1;
          s_d.st = DSR_IDLE;
        end
      end
      default:
      begin
        s_d.st = DSR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_q <= '0;
      s_q.st <= DSR_IDLE;
      s_q.po <= 4'(DSR_PO_CYC);
      s_q.pll_n <= DSR_PLLN_RST;
      s_q.single <= DSR_SINGLE_RST;
      s_q.load_n <= 1'h1;
      s_q.k <= 1'h1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // link outputs; output clocks in phase with k, held high during the power-on hold for single strap
  assign lnk.k = s_q.k;
  assign lnk.k_n = ~s_q.k;
  assign lnk.c = (s_q.single && s_q.po != 4'h0) ? 1'h1 : s_q.k;
  assign lnk.c_n = (s_q.single && s_q.po != 4'h0) ? 1'h1 : ~s_q.k;
  assign lnk.load_n = s_q.load_n;
  assign lnk.access_dir = 1'h1;
  assign lnk.addr = s_q.addr;
  assign lnk.byte_write_select_n = '1;
  assign lnk.pll_disable_n = s_q.pll_n;
  assign lnk.power_on = (s_q.po != 4'h0);
  assign lnk.d = s_q.addr[DSR_DW-1:0];

  // apb answers at once
  assign pready = 1'h1;
  always_comb
  begin
    prdata = 32'h0;
    pslverr = 1'h0;
    case (paddr)
      DSR_CTRL: prdata = 32'({s_q.single, s_q.pll_n, 1'h0});
      DSR_ADDR: prdata = 32'(s_q.addr);
      DSR_STAT: prdata = 32'({s_q.done, s_q.st != DSR_IDLE});
      DSR_DATA0: prdata = 32'(s_q.w0);
      DSR_DATA1: prdata = 32'(s_q.w1);
      default: pslverr = psel & penable;
    endcase
  end
endmodule

// ==== hdl/dsr_pkg.sv ====
// Purpose: shared constants and types for the burst sram read path
// Assumes: narrow variant, two-word bursts of 18-bit words
// Notes: apb offsets are byte addresses
package dsr_pkg;
  localparam int DSR_AW = 23; // address inputs
  localparam int DSR_DW = 18; // word width
  localparam int DSR_BW = 2; // byte selects
  // fixed pattern that stands in for the array contents
  localparam logic [DSR_DW-1:0] DSR_FILL = 18'h2a5a5;
  // half period of the link clock in clk cycles, and power-on length in link periods
  localparam int DSR_KHALF = 8;
  localparam int DSR_PO_CYC = 4;
  // half-periods after the request edge at which a word is sampled
  localparam logic [2:0] DSR_H_W1_SLOW = 3'h3;
  localparam logic [2:0] DSR_H_W1_FAST = 3'h2;
  // apb register offsets
  localparam logic [7:0] DSR_CTRL = 8'h00;
  localparam logic [7:0] DSR_ADDR = 8'h04;
  localparam logic [7:0] DSR_STAT = 8'h08;
  localparam logic [7:0] DSR_DATA0 = 8'h0c;
  localparam logic [7:0] DSR_DATA1 = 8'h10;
  // ctrl fields and reset values
  localparam int DSR_CTRL_START = 0;
  localparam int DSR_CTRL_PLLN = 1;
  localparam int DSR_CTRL_SINGLE = 2;
  localparam logic DSR_PLLN_RST = 1'h1;
  localparam logic DSR_SINGLE_RST = 1'h0;
  // status fields
  localparam int DSR_STAT_BUSY = 0;
  localparam int DSR_STAT_DONE = 1;

  typedef enum logic [2:0] {
    DSR_IDLE = 3'h1,
    DSR_ISSUE = 3'h2,
    DSR_WAIT = 3'h4
  } dsr_ctl_state_t;
endpackage

// ==== hdl/dsr_link_if.sv ====
// Purpose: pins between the memory controller and the sram read path
// Assumes: controller makes every clock on the link
// Notes: q_oe tells when the device drives the separate q data outputs
`timescale 1ns/10ps
interface dsr_link_if;
  import dsr_pkg::*;
  logic k; // true input clock
  logic k_n; // complement input clock
  logic c; // true output clock
  logic c_n; // complement output clock
  logic load_n; // access request, low active
  logic access_dir; // high = read
  logic [DSR_AW-1:0] addr; // address
  logic [DSR_BW-1:0] byte_write_select_n; // byte selects, low active
  logic pll_disable_n; // low = one-cycle latency mode
  logic power_on; // power-on hold, high active
  logic [DSR_DW-1:0] d; // data inputs
  logic [DSR_DW-1:0] q; // data outputs
  logic q_oe; // device drives q
  modport dev (input k, k_n, c, c_n, load_n, access_dir, addr, byte_write_select_n,
    pll_disable_n, power_on, d, output q, q_oe);
  modport ctl (output k, k_n, c, c_n, load_n, access_dir, addr, byte_write_select_n,
    pll_disable_n, power_on, d, input q, q_oe);
endinterface

// ==== hdl/dsr_sync3.sv ====
// Purpose: three-flop synchroniser for pin inputs
// Assumes: output moves only when second and third stage agree
// Notes: first stage is read by the second only
`timescale 1ns/10ps
module dsr_sync3 #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk, // sampling clock
  input wire logic rst, // synchronous reset
  input wire logic [W-1:0] din, // asynchronous input
  output logic [W-1:0] dout // filtered output
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] o;
  } dsr_sync_t;
  dsr_sync_t st_q, st_d;

  // shift, accept once the last two stages match
  always_comb
  begin
    st_d = st_q;
    st_d.s1 = din;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    if (st_q.s2 == st_q.s3)
    begin
      st_d.o = st_q.s3;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_q <= {4{INIT}};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign dout = st_q.o;
endmodule

// ==== hdl/dsr_dev.sv ====
// Purpose: read path and input clocking of a two-word-burst ddr sram
// Assumes: link clocks come from one source, c in phase with k
// Notes: array contents are a fixed function of the address
// Behaviour
// - pll_disable_n low selects legacy timing
// - legacy mode clocked at most 167 MHz
// - latency 1.5 cycles, or 1 when low
// - accesses start only on k rising
// - data inputs captured on both k edges
// - output registers on c pair, else k
// - controls sampled on k rising only
// - every access bursts two 18-bit words
// - read is access_dir high, load_n low
// - read address stored, lsb feeds burst counter
// - first word after next k rise
// - second word on the next c edge
// - started reads always run to completion
// - back-to-back reads every k rise allowed
// - deselect finishes bursts, then tristates
// - both c high at power-on: single clock
`timescale 1ns/10ps
module dsr_dev
  import dsr_pkg::*;
(
  dsr_link_if.dev lnk, // link pins
  output logic pll_off, // legacy one-cycle mode in use
  output logic single_clk, // single clock strap taken
  output logic [DSR_DW-1:0] din_rise, // data captured on k rise
  output logic [DSR_DW-1:0] din_fall // data captured on k_n rise
);
  // input-clock domain state
  typedef struct packed {
    logic strap_single;
    logic a_v;
    logic [DSR_AW-1:0] a_addr;
    logic b_v;
    logic [DSR_AW-1:0] b_addr;
    logic [DSR_DW-1:0] din;
  } dsr_kst_t;
  // output register state, one per output clock edge
  typedef struct packed {
    logic oe;
    logic [DSR_DW-1:0] q;
  } dsr_ost_t;
  // complement input edge state
  typedef struct packed {
    logic [DSR_DW-1:0] din;
  } dsr_nst_t;

  dsr_kst_t k_q, k_d;
  dsr_ost_t p_q, p_d;
  dsr_ost_t n_q, n_d;
  dsr_nst_t f_q, f_d;
  logic pll_on;
  logic oclk;
  logic kn_clk;

  // stand-in array: pattern mixed with the address
  // limitation: no write path, so reads only ever return this pattern
  function automatic logic [DSR_DW-1:0] dsr_word(input logic [DSR_AW-1:0] a);
    dsr_word = a[DSR_DW-1:0] ^ DSR_FILL;
  endfunction

  // latency pin is a board level, so it is filtered like any pin
  dsr_sync3 #(
    .W(1),
    .INIT(1'h1)
  ) u_pll_sync (
    .clk(lnk.k),
    .rst(lnk.power_on),
    .din(lnk.pll_disable_n),
    .dout(pll_on)
  );
  assign pll_off = ~pll_on;

  // output clock: c pair, or k pair when strapped single
  // oclk trails k by a delta, so its edge still sees the old k_q;
  // a c with real skew against k would need a proper crossing here
  assign oclk = k_q.strap_single ? lnk.k : lnk.c;
  assign kn_clk = lnk.k_n;

  // request pipeline on the true input clock
  always_comb
  begin
    k_d = k_q;
    k_d.din = lnk.d;
    // controls are seen only here, on k rising
    k_d.a_v = ~lnk.load_n & lnk.access_dir;
    if (!lnk.load_n)
    begin
      k_d.a_addr = lnk.addr;
    end
    // a started burst always moves on, nothing cancels it
    k_d.b_v = k_q.a_v;
    k_d.b_addr = k_q.a_addr;
  end

  always_ff @(posedge lnk.k)
  begin
    if (lnk.power_on)
    begin
      k_q <= '0;
      // strap: both output clocks held high at power-on
      // looked at only during the hold, so a running c cannot flip it
      k_q.strap_single <= lnk.c & lnk.c_n;
    end
    else
    begin
      k_q <= k_d;
    end
  end

  // complement input edge capture
  // captures are only observed; there is no write array behind them
  always_comb
  begin
    f_d = f_q;
    f_d.din = lnk.d;
  end

  always_ff @(posedge kn_clk)
  begin
    if (lnk.power_on)
    begin
      f_q <= '0;
    end
    else
    begin
      f_q <= f_d;
    end
  end

  // true output edge: first word in fast mode, second word in slow mode
  always_comb
  begin
    p_d = p_q;
    if (pll_on)
    begin
      p_d.oe = k_q.b_v;
      p_d.q = dsr_word({k_q.b_addr[DSR_AW-1:1], ~k_q.b_addr[0]});
    end
    else
    begin
      p_d.oe = k_q.a_v;
      p_d.q = dsr_word(k_q.a_addr);
    end
    // no pending word: drop drive at this true output edge
    if (!p_d.oe)
    begin
      p_d.q = '0;
    end
  end

  always_ff @(posedge oclk)
  begin
    if (lnk.power_on)
    begin
      p_q <= '0;
    end
    else
    begin
      p_q <= p_d;
    end
  end

  // complement output edge: first word slow, second word fast
  always_comb
  begin
    n_d = n_q;
    n_d.oe = k_q.b_v;
    if (pll_on)
    begin
      n_d.q = dsr_word(k_q.b_addr);
    end
    else
    begin
      n_d.q = dsr_word({k_q.b_addr[DSR_AW-1:1], ~k_q.b_addr[0]});
    end
    if (!n_d.oe)
    begin
      n_d.q = '0;
    end
  end

  always_ff @(negedge oclk)
  begin
    if (lnk.power_on)
    begin
      n_q <= '0;
    end
    else
    begin
      n_q <= n_d;
    end
  end

  // each half of the output clock shows the register of its own edge
  assign lnk.q = oclk ? p_q.q : n_q.q;
  assign lnk.q_oe = oclk ? p_q.oe : n_q.oe;
  assign single_clk = k_q.strap_single;
  assign din_rise = k_q.din;
  assign din_fall = f_q.din;
endmodule

// ==== tb/dsr_chk.sv ====
// Purpose: link checks for the burst sram read path
// Assumes: one request per start, mode held steady around reads
// Notes: samples on both edges of the true input clock
`timescale 1ns/10ps
module dsr_chk
  import dsr_pkg::*;
(
  input wire logic k, // true input clock
  input wire logic power_on, // power-on hold
  input wire logic load_n, // request, low active
  input wire logic access_dir, // high = read
  input wire logic [DSR_AW-1:0] addr, // address
  input wire logic pll_disable_n, // latency mode
  input wire logic [DSR_DW-1:0] q, // read data
  input wire logic q_oe // data drive enable
);
  // read request as seen at a clock edge
  sequence s_req;
    !load_n && access_dir;
  endsequence
  // two quiet true-clock rises after a request
  sequence s_gap;
    load_n [*2];
  endsequence
  // word sampled at a true clock rise, two rises after the request
  property p_pos(logic pl, logic sec);
    @(posedge k) disable iff (power_on)
    s_req ##0 (pll_disable_n == pl)
      |-> ##2 q_oe && q == (DSR_DW'($past(addr, 2)) ^ DSR_DW'(sec) ^ DSR_FILL);
  endproperty
  // falling-edge samples: first word in fast mode, second word in slow mode
  property p_neg(logic pl);
    @(negedge k) disable iff (power_on)
    s_req ##0 (pll_disable_n == pl)
      |-> ##1 (pl || (q_oe && q == (DSR_DW'($past(addr, 1)) ^ DSR_FILL)))
      ##1 (!pl || (q_oe && q == (DSR_DW'($past(addr, 2)) ^ DSR_DW'(1'b1) ^ DSR_FILL)));
  endproperty
  AST_W1_SLOW: assert property (p_pos(1'b1, 1'b0))
    else $error("first word wrong in slow mode");
  AST_W2_FAST: assert property (p_pos(1'b0, 1'b1))
    else $error("second word wrong in fast mode");
  AST_W1_FAST: assert property (p_neg(1'b0))
    else $error("first word wrong in fast mode");
  AST_W2_SLOW: assert property (p_neg(1'b1))
    else $error("second word wrong in slow mode");
  // no extra word once the burst is over
  AST_OFF: assert property (@(posedge k) disable iff (power_on)
    s_req ##1 s_gap |=> !q_oe)
    else $error("data drive not released after burst");
  AST_IDLE: assert property (@(negedge k) disable iff (power_on)
    load_n [*3] |-> !q_oe)
    else $error("data driven with no request");
  AST_ONE_REQ: assert property (@(posedge k) disable iff (power_on)
    !load_n |=> s_gap)
    else $error("request held too long");
  AST_DIR: assert property (@(posedge k) disable iff (power_on)
    !load_n |-> access_dir)
    else $error("request without read direction");
endmodule

// ==== tb/tb_top.sv ====
// Purpose: apb-driven bench for the sram read path, both ends joined
// Assumes: controller makes the link clocks from clk
// Notes: khalf cut to 6 to keep the run short
`timescale 1ns/10ps
module tb_top
  import dsr_pkg::*;
;
  localparam int KH = 6;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, pll_off, single_clk, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [DSR_DW-1:0] din_rise, din_fall;
  logic [DSR_AW-1:0] addrs [4] = '{23'h000000, 23'h7fffff, 23'h155555, 23'h02aaaa};
  int fail_count, comparisons;

  dsr_link_if dsr_link_if_i ();
  dsr_ctl #(.KHALF(KH)) dsr_ctl_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lnk(dsr_link_if_i.ctl));
  dsr_dev dsr_dev_i (.lnk(dsr_link_if_i.dev), .pll_off(pll_off), .single_clk(single_clk),
    .din_rise(din_rise), .din_fall(din_fall));
  dsr_chk dsr_chk_i (.k(dsr_link_if_i.k), .power_on(dsr_link_if_i.power_on),
    .load_n(dsr_link_if_i.load_n), .access_dir(dsr_link_if_i.access_dir),
    .addr(dsr_link_if_i.addr), .pll_disable_n(dsr_link_if_i.pll_disable_n),
    .q(dsr_link_if_i.q), .q_oe(dsr_link_if_i.q_oe));

  // 250 mhz system clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; unbounded wait on pready, data taken at that edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never gets an answer
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // one burst; the second start lands while busy and must be dropped
  // md is {single, pll_disable_n}, kept so the strap is not disturbed
  task automatic burst(input logic [DSR_AW-1:0] a, input logic [1:0] md);
    logic [DSR_DW-1:0] w;
    int n;
    w = a[DSR_DW-1:0] ^ DSR_FILL;
    n = 0;
    apb(1'b1, DSR_ADDR, 32'(a));
    apb(1'b1, DSR_CTRL, {29'h0, md, 1'b1});
    apb(1'b1, DSR_CTRL, {29'h0, md, 1'b1});
    do
    begin
      apb(1'b0, DSR_STAT, 32'h0);
      n++;
    end
    while (rd[DSR_STAT_DONE] !== 1'b1 && n < 100);
    chk(rd, 32'h2);
    apb(1'b0, DSR_DATA0, 32'h0);
    chk(rd, 32'(w));
    apb(1'b0, DSR_DATA1, 32'h0);
    chk(rd, 32'(w ^ 18'h1));
    chk(32'(din_rise), 32'(a[DSR_DW-1:0]));
    chk(32'(din_fall), 32'(a[DSR_DW-1:0]));
    chk(32'(dsr_link_if_i.q_oe), 32'h0);
    apb(1'b1, DSR_STAT, 32'h2);
    apb(1'b0, DSR_STAT, 32'h0);
    chk(rd, 32'h0);
  endtask

  // reset, defaults, refused address, bursts in both latency modes, then single clock
  initial
  begin
    fail_count = 0;
    comparisons = 0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    // start is ignored until the power-on hold has run out
    repeat (2 * KH * DSR_PO_CYC + 20) @(posedge clk);
    apb(1'b0, DSR_CTRL, 32'h0);
    chk(rd, 32'h2);
    chk(32'(single_clk), 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk(32'(er), 32'h1);
    for (int m = 0; m < 3; m++)
    begin
      apb(1'b1, DSR_CTRL, {29'h0, m[1], ~m[0], 1'b0});
      // mode pin is filtered in the device domain; a new strap reruns power-on
      repeat (30 * KH) @(posedge clk);
      chk(32'(pll_off), 32'(m[0]));
      chk(32'(single_clk), 32'(m[1]));
      foreach (addrs[i])
        burst(addrs[i], {m[1], ~m[0]});
    end
    wrap_up();
  end

  // hang guard, far above the expected run length
  initial
  begin
    repeat (40000) @(posedge clk);
    fail_count++;
    $display("[ERR] %0t run timed out", $time);
    wrap_up();
  end
endmodule
